// File: logic/cblnu_decode.sv
// Purpose: Pattern decode of the branch group
// Assumes: Instruction word in bits 23..0
// Notes: Purely combinational
`timescale 1ns/1ps
module cblnu_decode
   import cblnu_pkg::*;
(
   // Instruction
   input wire logic [23:0] insn,
   // Decoded
   output cblnu_pkg::cblnu_op_t op,
   output logic differs_const,
   output logic wide_offset
);
   import cblnu_pkg::*;
   logic [3:0] op0;
   logic [3:0] fld_t;
   logic [3:0] fld_r;
   assign op0 = insn[CBLNU_OP0_LSB +: 4];
   assign fld_t = insn[CBLNU_T_LSB +: 4];
   assign fld_r = insn[CBLNU_R_LSB +: 4];
   always_comb begin
      op = CBLNU_OP_NONE;
      differs_const = 1'b0;
      if (op0 == CBLNU_OP0_TWO_REG_OFFSET_FORMAT) begin // RULE14
         case (fld_r)
            CBLNU_R_SLT: op = CBLNU_OP_SLT;
            CBLNU_R_ULT: op = CBLNU_OP_ULT;
            CBLNU_R_NALL: op = CBLNU_OP_NALL;
            CBLNU_R_NE: op = CBLNU_OP_NE;
            default: op = CBLNU_OP_NONE;
         endcase
      end else if (op0 == CBLNU_OP0_BRI) begin // RULE14
         case (fld_t)
            CBLNU_T_SLTI: op = CBLNU_OP_SLTI;
            CBLNU_T_ULTI: op = CBLNU_OP_ULTI;
            CBLNU_T_LTZ: op = CBLNU_OP_LTZ;
            CBLNU_T_NEI: begin
               op = CBLNU_OP_NE;
               differs_const = 1'b1;
            end
            default: op = CBLNU_OP_NONE;
         endcase
      end
   end
   assign wide_offset = (op == CBLNU_OP_LTZ);
endmodule // cblnu_decode

// File: logic/cblnu_pkg.sv
// Purpose: Shared constants for the conditional branch less/not-equal unit
// Assumes: 24-bit instruction words in the low bits of the instruction input
// Notes: Opcode patterns are held here so decode and checks agree
package cblnu_pkg;
   localparam int unsigned CBLNU_XLEN = 32;
   localparam int unsigned CBLNU_CLK_MHZ = 40;
   // Instruction field positions
   localparam int unsigned CBLNU_OP0_LSB = 0;
   localparam int unsigned CBLNU_T_LSB = 4;
   localparam int unsigned CBLNU_S_LSB = 8;
   localparam int unsigned CBLNU_R_LSB = 12;
   localparam int unsigned CBLNU_OFS8_LSB = 16;
   localparam int unsigned CBLNU_OFS12_LSB = 12;
   localparam logic [3:0] CBLNU_OP0_TWO_REG_OFFSET_FORMAT = 4'h7;
   localparam logic [3:0] CBLNU_OP0_BRI = 4'h6;
   // Two-register forms: r field selects the test
   localparam logic [3:0] CBLNU_R_SLT = 4'h2;
   localparam logic [3:0] CBLNU_R_ULT = 4'h3;
   localparam logic [3:0] CBLNU_R_NALL = 4'hC;
   localparam logic [3:0] CBLNU_R_NE = 4'h9;
   // Register-constant forms: bits 7..4 select the test
   localparam logic [3:0] CBLNU_T_SLTI = 4'hA;
   localparam logic [3:0] CBLNU_T_ULTI = 4'hB;
   localparam logic [3:0] CBLNU_T_NEI = 4'h6;
   localparam logic [3:0] CBLNU_T_LTZ = 4'h9;
   localparam logic [31:0] CBLNU_SEQ_STEP = 32'h0000_0003;
   localparam logic [31:0] CBLNU_BR_BIAS = 32'h0000_0004;
   localparam logic [1:0] CBLNU_RST_SYNC = 2'h0;
   typedef enum logic [2:0] {
      CBLNU_OP_NONE = 3'b000,
      CBLNU_OP_SLT = 3'b001,
      CBLNU_OP_SLTI = 3'b010,
      CBLNU_OP_ULT = 3'b011,
      CBLNU_OP_ULTI = 3'b100,
      CBLNU_OP_LTZ = 3'b101,
      CBLNU_OP_NALL = 3'b110,
      CBLNU_OP_NE = 3'b111
   } cblnu_op_t;
endpackage

// File: logic/cblnu_target.sv
// Purpose: Taken-target adder for short and wide offsets
// Assumes: Offsets are two's complement
// Notes: Combinational
`timescale 1ns/1ps
module cblnu_target
   import cblnu_pkg::*;
(
   // Inputs
   input wire logic [31:0] pc,
   input wire logic [23:0] insn,
   input wire logic wide_offset,
   // Result
   output logic [31:0] target
);
   import cblnu_pkg::*;
   logic [31:0] ofs;
   always_comb begin
      if (wide_offset) begin
         ofs = {{20{insn[23]}}, insn[CBLNU_OFS12_LSB +: 12]}; // RULE8
      end else begin
         ofs = {{24{insn[23]}}, insn[CBLNU_OFS8_LSB +: 8]}; // RULE2
      end
   end
   assign target = pc + ofs + CBLNU_BR_BIAS;
endmodule // cblnu_target

// File: logic/cblnu_unit.sv
// Purpose: Condition evaluation and next-PC selection for the branch group
// Assumes: Register values are supplied in the same cycle as the instruction
// Notes: One-cycle latency from issue to result
`timescale 1ns/1ps
// Contract
// RULE1: Signed register less-than branch taken when first below second.
// RULE2: Short-offset target is pc plus sign-extended 8-bit offset plus four.
// RULE3: False condition goes to next sequential instruction.
// RULE4: Signed const less-than uses signed table indexed by r.
// RULE5: Unsigned register less-than compares zero-extended operands.
// RULE6: Unsigned const less-than uses separate unsigned table.
// RULE7: Negative branch taken exactly when bit 31 set.
// RULE8: Negative branch target uses sign-extended 12-bit offset plus four.
// RULE9: Not-all-set branch taken when mask and inverted value nonzero.
// RULE10: Not-all-set falls through when all masked bits are set.
// RULE11: Register differ branch taken when the two values differ.
// RULE12: Differ-const branch compares against signed table entry.
// RULE13: Each condition has an exact complement counterpart. The code decodes no complement forms; a false condition only falls through.
// RULE14: Decode from fixed opcode patterns and format positions.
// RULE15: Both constant tables are parameters.
module cblnu_unit
   import cblnu_pkg::*;
#(
   parameter logic [15:0][31:0] SIGNED_TABLE = '0,
   parameter logic [15:0][31:0] UNSIGNED_TABLE = '0
)(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Issue
   input wire logic issue_valid,
   input wire logic [23:0] insn,
   input wire logic [31:0] pc,
   input wire logic [31:0] first_reg,
   input wire logic [31:0] second_reg,
   // Result
   output logic result_valid,
   output logic is_branch,
   output logic taken,
   output logic [31:0] next_pc_out
);
   import cblnu_pkg::*;
   logic [1:0] rst_sync;
   logic rst_n_int;
   cblnu_op_t op;
   logic differs_const;
   logic wide_offset;
   logic [31:0] target;
   logic [31:0] s_const;
   logic [31:0] u_const;
   logic cond;
   logic [3:0] fld_r;

   function automatic logic in_group(cblnu_op_t o);
      return o != CBLNU_OP_NONE;
   endfunction

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync <= CBLNU_RST_SYNC;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync[1];

   cblnu_decode u_dec (
      .insn(insn),
      .op(op),
      .differs_const(differs_const),
      .wide_offset(wide_offset)
   );

   cblnu_target u_tgt (
      .pc(pc),
      .insn(insn),
      .wide_offset(wide_offset),
      .target(target)
   );

   assign fld_r = insn[CBLNU_R_LSB +: 4];
   assign s_const = SIGNED_TABLE[fld_r]; // RULE15
   assign u_const = UNSIGNED_TABLE[fld_r]; // RULE15

   // Taken conditions; no inverse group is decoded, a false condition selects fall-through
   always_comb begin
      case (op)
         CBLNU_OP_SLT: cond = $signed(first_reg) < $signed(second_reg); // RULE1
         CBLNU_OP_SLTI: cond = $signed(first_reg) < $signed(s_const); // RULE4
         CBLNU_OP_ULT: cond = first_reg < second_reg; // RULE5
         CBLNU_OP_ULTI: cond = first_reg < u_const; // RULE6
         CBLNU_OP_LTZ: cond = first_reg[31]; // RULE7
         CBLNU_OP_NALL: cond = |(second_reg & ~first_reg); // RULE9 RULE10
         CBLNU_OP_NE: cond = differs_const ? (first_reg != s_const) // RULE12
                                           : (first_reg != second_reg); // RULE11 RULE13
         default: cond = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         result_valid <= 1'b0;
      end else if (!rst_n_int) begin
         result_valid <= 1'b0;
      end else begin
         result_valid <= issue_valid;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         is_branch <= 1'b0;
         taken <= 1'b0;
         next_pc_out <= '0;
      end else if (!rst_n_int) begin
         is_branch <= 1'b0;
         taken <= 1'b0;
         next_pc_out <= '0;
      end else if (issue_valid) begin
         is_branch <= in_group(op);
         taken <= in_group(op) && cond;
         if (in_group(op) && cond) begin
            next_pc_out <= target; // RULE2 RULE8
         end else begin
            next_pc_out <= pc + CBLNU_SEQ_STEP; // RULE3
         end
      end
   end

   // Checks
   sequence s_issue_op(cblnu_op_t o);
      issue_valid && op == o;
   endsequence

   sequence s_issue_grp;
      issue_valid && in_group(op);
   endsequence

   property p_slt;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_SLT) |=> taken == $past($signed(first_reg) < $signed(second_reg));
   endproperty
   a_slt: assert property (p_slt) else $error("signed less mismatch"); // RULE1

   property p_short_target;
      @(posedge core_clk) disable iff (!rst_n_int)
      (issue_valid && op != CBLNU_OP_NONE && op != CBLNU_OP_LTZ && cond) |=>
         next_pc_out == $past(pc + {{24{insn[23]}}, insn[23:16]} + 32'h4);
   endproperty
   a_short_target: assert property (p_short_target) else $error("short target wrong"); // RULE2

   property p_fall;
      @(posedge core_clk) disable iff (!rst_n_int)
      (issue_valid && !cond) |=> !taken && next_pc_out == $past(pc) + CBLNU_SEQ_STEP;
   endproperty
   a_fall: assert property (p_fall) else $error("fall through wrong"); // RULE3

   property p_slti;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_SLTI) |=> taken == $past($signed(first_reg) < $signed(s_const));
   endproperty
   a_slti: assert property (p_slti) else $error("signed const less mismatch"); // RULE4

   property p_ult;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_ULT) |=> taken == $past(first_reg < second_reg);
   endproperty
   a_ult: assert property (p_ult) else $error("unsigned less mismatch"); // RULE5

   property p_ulti;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_ULTI) |=> taken == $past(first_reg < u_const);
   endproperty
   a_ulti: assert property (p_ulti) else $error("unsigned const mismatch"); // RULE6

   property p_ltz;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_LTZ) |=> taken == $past(first_reg[31]);
   endproperty
   a_ltz: assert property (p_ltz) else $error("negative test mismatch"); // RULE7

   property p_wide_target;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_LTZ) ##0 first_reg[31] |=>
         next_pc_out == $past(pc + {{20{insn[23]}}, insn[23:12]} + 32'h4);
   endproperty
   a_wide_target: assert property (p_wide_target) else $error("wide target wrong"); // RULE8

   property p_nall;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_NALL) |=> taken == $past((second_reg & first_reg) != second_reg);
   endproperty
   a_nall: assert property (p_nall) else $error("not-all-set mismatch"); // RULE9 RULE10

   property p_ne;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_NE) ##0 !differs_const |=> taken == $past(first_reg != second_reg);
   endproperty
   a_ne: assert property (p_ne) else $error("register differ mismatch"); // RULE11

   property p_nei;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_NE) ##0 differs_const |=> taken == $past(first_reg != s_const);
   endproperty
   a_nei: assert property (p_nei) else $error("const differ mismatch"); // RULE12

   property p_decode;
      @(posedge core_clk) disable iff (!rst_n_int)
      (issue_valid && insn[3:0] != CBLNU_OP0_TWO_REG_OFFSET_FORMAT && insn[3:0] != CBLNU_OP0_BRI) |=> !is_branch;
   endproperty
   a_decode: assert property (p_decode) else $error("foreign opcode decoded"); // RULE14

   property p_group;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_grp |=> is_branch && result_valid;
   endproperty
   a_group: assert property (p_group) else $error("group insn not flagged"); // RULE14

   property p_refused;
      @(posedge core_clk) disable iff (!rst_n_int)
      (issue_valid && op == CBLNU_OP_NONE) |=> !is_branch && !taken;
   endproperty
   a_refused: assert property (p_refused) else $error("foreign insn taken"); // RULE14

   property p_taken_branch;
      @(posedge core_clk) disable iff (!rst_n_int)
      taken |-> is_branch;
   endproperty
   a_taken_branch: assert property (p_taken_branch) else $error("taken outside group"); // RULE14

   property p_const_sel;
      @(posedge core_clk) disable iff (!rst_n_int)
      differs_const |-> op == CBLNU_OP_NE && insn[CBLNU_T_LSB +: 4] == CBLNU_T_NEI;
   endproperty
   a_const_sel: assert property (p_const_sel) else $error("const compare misselected"); // RULE12

   property p_wide_sel;
      @(posedge core_clk) disable iff (!rst_n_int)
      wide_offset |-> insn[3:0] == CBLNU_OP0_BRI && insn[7:4] == CBLNU_T_LTZ;
   endproperty
   a_wide_sel: assert property (p_wide_sel) else $error("wide offset misselected"); // RULE8

   // Complement checks, independent of cond
   property p_slt_fall;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_SLT) ##0 !($signed(first_reg) < $signed(second_reg)) |=>
         !taken && next_pc_out == $past(pc) + CBLNU_SEQ_STEP;
   endproperty
   a_slt_fall: assert property (p_slt_fall) else $error("signed less fall wrong"); // RULE13

   property p_slti_fall;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_SLTI) ##0 !($signed(first_reg) < $signed(s_const)) |=>
         !taken && next_pc_out == $past(pc) + CBLNU_SEQ_STEP;
   endproperty
   a_slti_fall: assert property (p_slti_fall) else $error("signed const fall wrong"); // RULE4

   property p_ult_fall;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_ULT) ##0 first_reg >= second_reg |=>
         !taken && next_pc_out == $past(pc) + CBLNU_SEQ_STEP;
   endproperty
   a_ult_fall: assert property (p_ult_fall) else $error("unsigned less fall wrong"); // RULE13

   property p_ulti_fall;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_ULTI) ##0 first_reg >= u_const |=>
         !taken && next_pc_out == $past(pc) + CBLNU_SEQ_STEP;
   endproperty
   a_ulti_fall: assert property (p_ulti_fall) else $error("unsigned const fall wrong"); // RULE6

   property p_ltz_fall;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_LTZ) ##0 !first_reg[31] |=>
         !taken && next_pc_out == $past(pc) + CBLNU_SEQ_STEP;
   endproperty
   a_ltz_fall: assert property (p_ltz_fall) else $error("negative fall wrong"); // RULE3

   property p_nall_fall;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_NALL) ##0 (second_reg & first_reg) == second_reg |=>
         !taken && next_pc_out == $past(pc) + CBLNU_SEQ_STEP;
   endproperty
   a_nall_fall: assert property (p_nall_fall) else $error("all-set fall wrong"); // RULE10

   property p_ne_fall;
      @(posedge core_clk) disable iff (!rst_n_int)
      s_issue_op(CBLNU_OP_NE) ##0 (!differs_const && first_reg == second_reg) |=>
         !taken && next_pc_out == $past(pc) + CBLNU_SEQ_STEP;
   endproperty
   a_ne_fall: assert property (p_ne_fall) else $error("register equal fall wrong"); // RULE13

   // Output framing and reset
   property p_valid;
      @(posedge core_clk) disable iff (!rst_n_int)
      issue_valid |=> result_valid;
   endproperty
   a_valid: assert property (p_valid) else $error("result valid missing");

   property p_idle;
      @(posedge core_clk) disable iff (!rst_n_int)
      !issue_valid |=> !result_valid;
   endproperty
   a_idle: assert property (p_idle) else $error("result valid without issue");

   property p_hold;
      @(posedge core_clk) disable iff (!rst_n_int)
      !issue_valid |=> $stable(is_branch) && $stable(taken) && $stable(next_pc_out);
   endproperty
   a_hold: assert property (p_hold) else $error("outputs moved without issue");

   property p_reset_quiet;
      @(posedge core_clk)
      !rst_n_int |=> !result_valid && !is_branch && !taken && next_pc_out == '0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
endmodule // cblnu_unit

// File: tb/cblnu_unit_tb_top.sv
// Purpose: Self-checking bench for the branch condition unit
// Assumes: One-cycle answer, issue from the third edge after reset release
// Notes: Table rows run back to back; reset cases follow by hand
`timescale 1ns/1ps
module cblnu_unit_tb_top;
   import cblnu_pkg::*;
   typedef struct packed {
      logic [23:0] insn;
      logic [31:0] pc;
      logic [31:0] a;
      logic [31:0] b;
      logic [1:0] res;
   } cblnu_row_t;
   // Nonzero entries chosen so signed and unsigned tables disagree
   localparam logic [15:0][31:0] ST = (512'h40 << 160) | (512'hFFFFFFF0 << 96);
   localparam logic [15:0][31:0] UT = (512'hFFFFFF00 << 96) | (512'h8000 << 64);
   localparam int NROW = 23;
   logic core_clk = 1'h0;
   logic reset_n = 1'h0;
   logic issue_valid = 1'h0;
   logic [23:0] insn = 24'h0;
   logic [31:0] pc = 32'h0;
   logic [31:0] first_reg = 32'h0;
   logic [31:0] second_reg = 32'h0;
   logic result_valid;
   logic is_branch;
   logic taken;
   logic [31:0] next_pc_out;
   int err_count = 0;
   int compares = 0;
   // Result field: is_branch then taken
   cblnu_row_t rows [NROW] = '{
      '{24'h102127, 32'h1000, 32'hFFFFFFFB, 32'h3, 2'h3},
      '{24'h802127, 32'h1000, 32'h3, 32'hFFFFFFFB, 2'h2},
      '{24'h7F3127, 32'hFFFFFFFE, 32'h3, 32'hFFFFFFFB, 2'h3},
      '{24'h7F3127, 32'h1000, 32'hFFFFFFFB, 32'h3, 2'h2},
      '{24'hF031A6, 32'h1000, 32'hFFFFFFE0, 32'h0, 2'h3},
      '{24'hF031A6, 32'h1000, 32'hFFFFFFF0, 32'h0, 2'h2},
      '{24'h2021B6, 32'h1000, 32'h7FFF, 32'h0, 2'h3},
      '{24'h2021B6, 32'h1000, 32'h8000, 32'h0, 2'h2},
      '{24'h800196, 32'h1000, 32'h80000000, 32'h0, 2'h3},
      '{24'h7FF196, 32'h1000, 32'h80000001, 32'h0, 2'h3},
      '{24'h7FF196, 32'h1000, 32'h7FFFFFFF, 32'h0, 2'h2},
      '{24'h04C127, 32'h1000, 32'hF0, 32'hF0, 2'h2},
      '{24'h04C127, 32'h1000, 32'hFFFFFF70, 32'hF0, 2'h3},
      '{24'h04C127, 32'h1000, 32'h0, 32'h0, 2'h2},
      '{24'h089127, 32'h1000, 32'h12345678, 32'h12345678, 2'h2},
      '{24'h089127, 32'h1000, 32'h92345678, 32'h12345678, 2'h3},
      '{24'h0C5166, 32'h1000, 32'h40, 32'h0, 2'h2},
      '{24'h0C5166, 32'h1000, 32'h41, 32'h0, 2'h3},
      '{24'h0C3166, 32'h1000, 32'hFFFFFFF0, 32'h0, 2'h2},
      '{24'h100127, 32'h1000, 32'h1, 32'h2, 2'h0},
      '{24'h10A127, 32'h1000, 32'h1, 32'h2, 2'h0},
      '{24'h0C5156, 32'h1000, 32'h41, 32'h0, 2'h0},
      '{24'h102125, 32'h1000, 32'h1, 32'h2, 2'h0}
   };

   cblnu_unit #(.SIGNED_TABLE(ST), .UNSIGNED_TABLE(UT)) dut (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .issue_valid(issue_valid),
      .insn(insn),
      .pc(pc),
      .first_reg(first_reg),
      .second_reg(second_reg),
      .result_valid(result_valid),
      .is_branch(is_branch),
      .taken(taken),
      .next_pc_out(next_pc_out)
   );

   always #12.5 core_clk = ~core_clk;

   function automatic logic [31:0] exp_pc(cblnu_row_t w);
      logic [31:0] ofs;
      if (w.insn[3:0] == 4'h6 && w.insn[7:4] == 4'h9) begin
         ofs = {{20{w.insn[23]}}, w.insn[23:12]};
      end else begin
         ofs = {{24{w.insn[23]}}, w.insn[23:16]};
      end
      return w.res[0] ? w.pc + ofs + CBLNU_BR_BIAS : w.pc + CBLNU_SEQ_STEP;
   endfunction

   task automatic chk1(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic drive(input cblnu_row_t w, input logic v);
      issue_valid <= v;
      insn <= w.insn;
      pc <= w.pc;
      first_reg <= w.a;
      second_reg <= w.b;
   endtask

   task automatic check_row(input cblnu_row_t w, input logic v);
      chk1("result_valid", v, result_valid);
      chk1("is_branch", w.res[1], is_branch);
      chk1("taken", w.res[0], taken);
      chk32("next_pc_out", exp_pc(w), next_pc_out);
   endtask

   task automatic end_sim;
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      end_sim();
   end

   initial begin
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk1("result_valid", 1'h0, result_valid);
      chk32("next_pc_out", 32'h0, next_pc_out);
      @(posedge core_clk);
      reset_n <= 1'h1;
      repeat (2) @(posedge core_clk);
      // Back to back issue, result checked one cycle later
      for (int i = 0; i <= NROW; i++) begin
         @(posedge core_clk);
         drive(rows[i % NROW], i < NROW);
         if (i > 0) begin
            @(negedge core_clk);
            check_row(rows[i - 1], 1'h1);
         end
      end
      // Outputs stand after valid drops at the end of the run
      @(negedge core_clk);
      check_row(rows[NROW - 1], 1'h0);
      // Reset in mid-run clears outputs at once
      @(posedge core_clk);
      drive(rows[0], 1'h1);
      @(posedge core_clk);
      issue_valid <= 1'h0;
      @(posedge core_clk);
      reset_n <= 1'h0;
      #1;
      chk1("is_branch", 1'h0, is_branch);
      chk1("taken", 1'h0, taken);
      chk32("next_pc_out", 32'h0, next_pc_out);
      @(posedge core_clk);
      reset_n <= 1'h1;
      // Outputs stay clear for two edges, issue taken at the third
      for (int k = 0; k < 3; k++) begin
         if (k == 2) begin
            drive(rows[0], 1'h1);
         end
         @(negedge core_clk);
         chk1("result_valid", 1'h0, result_valid);
         chk32("next_pc_out", 32'h0, next_pc_out);
         @(posedge core_clk);
      end
      issue_valid <= 1'h0;
      @(negedge core_clk);
      check_row(rows[0], 1'h1);
      @(posedge core_clk);
      drive(rows[15], 1'h1);
      @(posedge core_clk);
      issue_valid <= 1'h0;
      @(negedge core_clk);
      check_row(rows[15], 1'h1);
      end_sim();
   end
endmodule // cblnu_unit_tb_top
